// File: src/clm_core.sv
// Character display memory with host register-select port and pattern lookup.
// Host strobes are single-cycle and synchronous to clk; read data appears one cycle after rd.
`default_nettype none
module clm_core #(
  parameter int VISIBLE = 8,
  parameter int BUSY_LEN = clm_pkg::BUSY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host port
  input wire clm_pkg::clm_host_req_t host,
  output logic [7:0] rdata,
  output logic busy_indicator,
  // Refresh scan
  input wire logic [2:0] scan_pos,
  input wire logic scan_row2,
  input wire logic [3:0] scan_line,
  output logic [4:0] pixels,
  output logic [6:0] display_mem_addr
);
  initial begin
    if (VISIBLE < 1 || VISIBLE > 8 || BUSY_LEN < 1 || BUSY_LEN > 255)
      $error("clm_core: unsupported parameters");
  end

  logic [7:0] char_code_ram [clm_pkg::CHAR_MEM_DEPTH];
  logic [7:0] pattern_ram [clm_pkg::PAT_MEM_DEPTH];
  logic [7:0] command_register;
  logic [7:0] data_holding_register;
  logic [6:0] address_pointer;
  logic sel_pattern;
  logic two_line;
  logic tall_font;
  logic step_up;
  logic [6:0] shift_base;
  logic [7:0] busy_cnt;
  logic pend_fetch;
  clm_pkg::clm_state_t state;

  // Pointer step with wrap inside the selected memory
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic pat, input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (pat)
      r = {1'b0, r[5:0]};
    else if (two)
    begin
      if (up && a == clm_pkg::LINE1_LAST) r = clm_pkg::LINE2_FIRST;
      else if (up && a == clm_pkg::LINE2_LAST) r = clm_pkg::LINE1_FIRST;
      else if (!up && a == clm_pkg::LINE2_FIRST) r = clm_pkg::LINE1_LAST;
      else if (!up && a == clm_pkg::LINE1_FIRST) r = clm_pkg::LINE2_LAST;
    end
    else
    begin
      if (up && a == clm_pkg::ONE_LINE_LAST) r = clm_pkg::LINE1_FIRST;
      else if (!up && a == clm_pkg::LINE1_FIRST) r = clm_pkg::ONE_LINE_LAST;
    end
    return r;
  endfunction

  // Character memory index from a pointer value (line two sits after line one)
  function automatic logic [6:0] char_index(input logic [6:0] a, input logic two);
    if (two && a[6])
      return 7'(a[5:0]) + 7'(clm_pkg::LINE1_LAST) + 7'h01;
    else
      return a;
  endfunction

  wire logic is_cmd_wr = host.wr && !host.register_select;
  wire logic is_dat_wr = host.wr && host.register_select;
  wire logic is_dat_rd = host.rd && host.register_select;
  wire logic accept_cmd = is_cmd_wr && !busy_indicator;
  wire logic [6:0] next_ptr = step_addr(address_pointer, step_up, sel_pattern, two_line);

  // Command register, mode bits and busy timing
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      command_register <= 8'h00;
      sel_pattern <= 1'b0;
      two_line <= 1'b0;
      tall_font <= 1'b0;
      step_up <= 1'b1;
      shift_base <= 7'h00;
      busy_cnt <= 8'h00;
      busy_indicator <= 1'b0;
      state <= clm_pkg::CLM_IDLE;
      pend_fetch <= 1'b0;
    end
    else
    begin
      pend_fetch <= 1'b0;
      case (state)
        clm_pkg::CLM_IDLE:
        begin
          if (accept_cmd)
          begin
            command_register <= host.wdata;
            busy_indicator <= 1'b1;
            busy_cnt <= 8'(BUSY_LEN);
            state <= clm_pkg::CLM_BUSY;
            if (host.wdata[7])
              sel_pattern <= 1'b0;
            else if (host.wdata[6])
              sel_pattern <= 1'b1;
            else if (host.wdata[5])
            begin
              two_line <= host.wdata[clm_pkg::FN_LINES_BIT];
              tall_font <= host.wdata[clm_pkg::FN_FONT_BIT];
            end
            else if (host.wdata[4])
            begin
              if (host.wdata[clm_pkg::SHIFT_DISPLAY_BIT])
                shift_base <= host.wdata[clm_pkg::SHIFT_RIGHT_BIT]
                  ? step_addr(shift_base, 1'b0, 1'b0, 1'b1) & 7'h3F
                  : step_addr(shift_base, 1'b1, 1'b0, 1'b1) & 7'h3F;
            end
            else if (host.wdata[2])
              step_up <= host.wdata[clm_pkg::ENTRY_INC_BIT];
          end
        end
        clm_pkg::CLM_BUSY:
        begin
          busy_cnt <= busy_cnt - 8'h01;
          if (busy_cnt == 8'h01)
          begin
            busy_indicator <= 1'b0;
            state <= clm_pkg::CLM_IDLE;
            pend_fetch <= command_register[7] || command_register[6];
          end
        end
        default:
          state <= clm_pkg::CLM_IDLE;
      endcase
    end
  end

  // Address pointer: set by address commands, stepped on every data access
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      address_pointer <= 7'h00;
    else if (accept_cmd && host.wdata[7])
      address_pointer <= host.wdata[6:0];
    else if (accept_cmd && host.wdata[6])
      address_pointer <= {1'b0, host.wdata[5:0]};
    else if (is_dat_wr || is_dat_rd)
      address_pointer <= next_ptr;
  end

  // Memories: written straight from the host write data on a data write
  always_ff @(posedge clk)
  begin
    if (is_dat_wr && sel_pattern)
      pattern_ram[address_pointer[5:0]] <= host.wdata;
    if (is_dat_wr && !sel_pattern && char_index(address_pointer, two_line) < 7'(clm_pkg::CHAR_MEM_DEPTH))
      char_code_ram[char_index(address_pointer, two_line)] <= host.wdata;
  end

  // Data holding register: latched on write, prefetched after address set and after read
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      data_holding_register <= 8'h00;
    else if (is_dat_wr)
      data_holding_register <= host.wdata;
    else if (is_dat_rd)
      data_holding_register <= sel_pattern ? pattern_ram[next_ptr[5:0]]
        : char_code_ram[char_index(next_ptr, two_line)];
    else if (pend_fetch)
      data_holding_register <= sel_pattern ? pattern_ram[address_pointer[5:0]]
        : char_code_ram[char_index(address_pointer, two_line)];
  end

  // Host read data
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (host.rd && !host.register_select)
      rdata <= {busy_indicator, address_pointer};
    else if (is_dat_rd)
      rdata <= data_holding_register;
    else
      rdata <= 8'h00;
  end

  // Refresh path: window position to memory address, then code to dots
  logic [6:0] win_addr;
  logic [7:0] scan_code;
  clm_pkg::clm_rom_addr_t rom_addr;
  logic [7:0] rom_word;
  logic [7:0] user_word;
  logic [3:0] last_line;
  always_comb
  begin
    win_addr = 7'((7'(shift_base) + 7'(scan_pos)) % 7'h28);
    if (!two_line)
      win_addr = 7'((7'(shift_base) + 7'(scan_pos)) % 7'h50);
    else if (scan_row2)
      win_addr = win_addr + clm_pkg::LINE2_FIRST;
    scan_code = char_code_ram[char_index(win_addr, two_line)];
    rom_addr = '{code: scan_code, line: scan_line};
    last_line = tall_font ? clm_pkg::LAST_LINE_5X10 : clm_pkg::LAST_LINE_5X8;
    if (rom_addr.code[7:4] == clm_pkg::USER_CODE_HIGH || rom_addr.line > last_line)
      rom_word = 8'h00;
    else
      rom_word = clm_pkg::UNPROGRAMMED & {3'h0, rom_addr.code[4:0] ^ {1'b0, rom_addr.line}};
    if (tall_font)
      user_word = pattern_ram[{rom_addr.code[2:1], rom_addr.line}];
    else
      user_word = pattern_ram[{rom_addr.code[2:0], rom_addr.line[2:0]}];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pixels <= 5'h00;
      display_mem_addr <= 7'h00;
    end
    else
    begin
      display_mem_addr <= win_addr;
      if (scan_code[7:4] == clm_pkg::USER_CODE_HIGH && scan_line <= last_line)
        pixels <= user_word[4:0];
      else
        pixels <= rom_word[4:0];
    end
  end

  busy_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
    busy_indicator && is_cmd_wr |=> $stable(command_register)) else $error("command taken while busy");
  status_read_a: assert property (@(posedge clk) disable iff (!rstn)
    host.rd && !host.register_select |=> rdata == {$past(busy_indicator), $past(address_pointer)})
    else $error("status read wrong");
  cmd_take_a: assert property (@(posedge clk) disable iff (!rstn)
    is_cmd_wr && !busy_indicator |=> command_register == $past(host.wdata) && busy_indicator)
    else $error("command not taken");
  ptr_step_a: assert property (@(posedge clk) disable iff (!rstn)
    (is_dat_wr || is_dat_rd) && !is_cmd_wr |=> address_pointer == $past(next_ptr)) else $error("pointer not stepped");
  data_latch_a: assert property (@(posedge clk) disable iff (!rstn)
    is_dat_wr |=> data_holding_register == $past(host.wdata)) else $error("data not latched");
  data_read_a: assert property (@(posedge clk) disable iff (!rstn)
    is_dat_rd |=> rdata == $past(data_holding_register)) else $error("data read wrong");
  rom_high_a: assert property (@(posedge clk) disable iff (!rstn)
    rom_word[7:5] == 3'h0) else $error("rom high bits set");
  user_rom_a: assert property (@(posedge clk) disable iff (!rstn)
    scan_code[7:4] == 4'h0 |-> rom_word == 8'h00) else $error("user range rom not zero");
  busy_end_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(busy_indicator) |-> ##[1:255] !busy_indicator) else $error("busy never clears");
endmodule
`default_nettype wire

// File: src/clm_pkg.sv
// Package for the character display memory block: geometry, encodings, bus carrier.
// Assumes a single 200 MHz clock domain and a synchronous host port.
`default_nettype none
package clm_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CHAR_MEM_DEPTH = 80;
  localparam int PAT_MEM_DEPTH = 64;
  localparam logic [6:0] LINE1_FIRST = 7'h00;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  localparam logic [3:0] USER_CODE_HIGH = 4'h0;
  localparam logic [3:0] LAST_LINE_5X8 = 4'h7;
  localparam logic [3:0] LAST_LINE_5X10 = 4'hA;
  localparam logic [7:0] UNPROGRAMMED = 8'h1F;
  localparam int BUSY_NS = 40;
  localparam int BUSY_CYCLES = (BUSY_NS * CLK_MHZ + 999) / 1000;
  // Command encodings (highest set bit selects the command)
  localparam logic [7:0] CMD_SET_CHAR_ADDR = 8'h80;
  localparam logic [7:0] CMD_SET_PAT_ADDR = 8'h40;
  localparam logic [7:0] CMD_FUNCTION = 8'h20;
  localparam logic [7:0] CMD_SHIFT = 8'h10;
  localparam logic [7:0] CMD_ENTRY = 8'h04;
  localparam int FN_LINES_BIT = 3;
  localparam int FN_FONT_BIT = 2;
  localparam int SHIFT_DISPLAY_BIT = 3;
  localparam int SHIFT_RIGHT_BIT = 2;
  localparam int ENTRY_INC_BIT = 1;
  typedef struct packed {
    logic rd;
    logic wr;
    logic register_select;
    logic [7:0] wdata;
  } clm_host_req_t;
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] line;
  } clm_rom_addr_t;
  typedef enum logic [2:0] {
    CLM_IDLE = 3'b001,
    CLM_BUSY = 3'b010,
    CLM_FETCH = 3'b100
  } clm_state_t;
endpackage
`default_nettype wire

// File: verif/clm_host_model.sv
// Host processor model: single-cycle strobes on the register-select port.
// Assumes clk is the block clock; read data is taken one cycle after the strobe.
`default_nettype none
module clm_host_model (
  // Clock
  input wire logic clk,
  // Host port
  output var clm_pkg::clm_host_req_t host,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int stuck = 0;
  initial host = '0;
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    host <= '{rd: rd, wr: !rd, register_select: rs, wdata: d};
    @(posedge clk);
    host <= '0;
    #1 q = rdata;
  endtask
  // Bounded poll, so a stuck busy cannot hang the host
  task automatic wait_ready();
    logic [7:0] q;
    int n = 0;
    do
    begin
      xfer(1'b0, 1'b1, 8'h00, q);
      n++;
    end
    while (q[7] !== 1'b0 && n < 40);
    if (n >= 40) stuck++;
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [7:0] q;
    wait_ready();
    xfer(1'b0, 1'b0, c, q);
  endtask
  task automatic data(input logic rd, input logic [7:0] d, output logic [7:0] q);
    wait_ready();
    xfer(1'b1, rd, d, q);
  endtask
endmodule
`default_nettype wire

// File: verif/clm_core_tb.sv
// Self-checking bench for the character display memory block.
// Assumes the host model drives the port and the bench drives the scan inputs.
`default_nettype none
module clm_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUSY_LEN = 8;
  logic clk;
  logic rstn;
  clm_pkg::clm_host_req_t host;
  logic [7:0] rdata;
  logic busy_indicator;
  logic [2:0] scan_pos;
  logic scan_row2;
  logic [3:0] scan_line;
  logic [4:0] pixels;
  logic [6:0] display_mem_addr;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] q;
  // Mode command, set-address command, data byte, pointer after one access
  logic [31:0] rows [5] = '{32'h208041_01, 32'h20CFA5_00, 32'h28A73C_40, 32'h28E75A_00, 32'h207E15_3F};
  clm_core #(.VISIBLE(8), .BUSY_LEN(BUSY_LEN)) uut (.clk(clk), .rstn(rstn), .host(host), .rdata(rdata),
    .busy_indicator(busy_indicator), .scan_pos(scan_pos), .scan_row2(scan_row2), .scan_line(scan_line),
    .pixels(pixels), .display_mem_addr(display_mem_addr));
  clm_host_model host_m (.clk(clk), .host(host), .rdata(rdata));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // Scan inputs are levels; the lookup is registered, so give it a few edges
  task automatic look(input logic [2:0] p, input logic r2, input logic [3:0] l);
    @(posedge clk);
    scan_pos <= p;
    scan_row2 <= r2;
    scan_line <= l;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    rstn = 1'b0;
    scan_pos = 3'h0;
    scan_row2 = 1'b0;
    scan_line = 4'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      host_m.cmd(rows[i][31:24]);
      host_m.cmd(rows[i][23:16]);
      host_m.data(1'b0, rows[i][15:8], q);
      host_m.cmd(rows[i][23:16]);
      host_m.data(1'b1, 8'h00, q);
      chk(q, rows[i][15:8], "readback");
      host_m.xfer(1'b0, 1'b1, 8'h00, q);
      chk(q, rows[i][7:0], "pointer");
    end
    $display("row tests done");
    host_m.cmd(8'h04);
    host_m.cmd(8'h85);
    host_m.data(1'b0, 8'h77, q);
    host_m.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h04, "pointer down");
    host_m.cmd(8'h06);
    host_m.cmd(8'h90);
    // Busy is already up at the first look, so count high samples from zero
    n = 0;
    while (busy_indicator === 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(8'(n), 8'(BUSY_LEN), "busy length");
    host_m.cmd(8'hA5);
    host_m.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'hA5, "busy on bit 7");
    // Command sent while busy, without polling: must be dropped
    host_m.xfer(1'b0, 1'b0, 8'h80, q);
    host_m.wait_ready();
    host_m.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h25, "refused");
    $display("busy tests done");
    host_m.cmd(8'h20);
    look(3'h5, 1'b0, 4'h0);
    chk({1'b0, display_mem_addr}, 8'h05, "one line");
    host_m.cmd(8'h28);
    look(3'h3, 1'b1, 4'h0);
    chk({1'b0, display_mem_addr}, 8'h43, "two line");
    host_m.cmd(8'h1C);
    look(3'h0, 1'b0, 4'h0);
    chk({1'b0, display_mem_addr}, 8'h27, "right wrap 1");
    look(3'h0, 1'b1, 4'h0);
    chk({1'b0, display_mem_addr}, 8'h67, "right wrap 2");
    host_m.cmd(8'h18);
    host_m.cmd(8'h18);
    look(3'h7, 1'b1, 4'h0);
    chk({1'b0, display_mem_addr}, 8'h48, "left shift");
    host_m.cmd(8'h1C);
    host_m.cmd(8'h82);
    host_m.data(1'b0, 8'h08, q);
    host_m.data(1'b0, 8'h41, q);
    host_m.cmd(8'h43);
    host_m.data(1'b0, 8'hEB, q);
    look(3'h2, 1'b0, 4'h3);
    chk({3'h0, pixels}, 8'h0B, "user pattern");
    look(3'h3, 1'b0, 4'h9);
    chk({3'h0, pixels}, 8'h00, "5x8 tail");
    host_m.cmd(8'h2C);
    look(3'h3, 1'b0, 4'hB);
    chk({3'h0, pixels}, 8'h00, "5x10 tail");
    look(3'h2, 1'b0, 4'h3);
    chk({3'h0, pixels}, 8'h0B, "5x10 user");
    $display("display tests done");
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    chk({busy_indicator, display_mem_addr}, 8'h00, "reset busy addr");
    chk(rdata | {3'h0, pixels}, 8'h00, "reset data");
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    look(3'h1, 1'b1, 4'h0);
    chk({1'b0, display_mem_addr}, 8'h01, "mode after reset");
    chk(8'(host_m.stuck), 8'h00, "busy stuck");
    $display("reset tests done");
    stop_test();
  end
endmodule
`default_nettype wire
